// ### csm_pkg.sv
// Package for the compare-skip and move decode block.
// Assumes 16-bit instruction words and an 8-bit data path with 12-bit data addresses.
package csm_pkg;
    // ************************************************************
    // Widths, opcodes and reset values
    // ************************************************************
    localparam int           DATA_W      = 8;
    localparam int           ADDR_W      = 12;
    localparam logic [6:0]   OP_CPSLT    = 7'h30;       // 0110_000a
    localparam logic [6:0]   OP_CPSGT    = 7'h32;       // 0110_010a
    localparam logic [3:0]   OP_MOVE1    = 4'hC;        // Move, first word
    localparam logic [3:0]   OP_MOVE2    = 4'hF;        // Any second word
    localparam logic [7:0]   OP_BSLOAD   = 8'h01;       // Bank select literal load
    localparam logic [7:0]   BANK_SEL_RESET = 8'h00;
    localparam logic [7:0]   ACCESS_SPLIT = 8'h80;      // Access bank low/high split
    localparam logic [3:0]   ACCESS_HIBANK = 4'hF;
    localparam logic [1:0]   Q1 = 2'd0;
    localparam logic [1:0]   Q2 = 2'd1;
    localparam logic [1:0]   Q3 = 2'd2;
    localparam logic [1:0]   Q4 = 2'd3;
    typedef enum logic [1:0] {ST_EXEC, ST_SKIP, ST_MOVE2} csm_state_e;
endpackage

// ### csm_qgen.sv
// Quarter phase generator: four clocks per instruction cycle.
// Assumes a single core clock and asynchronous active-low reset.
`timescale 1ns/1ps
module csm_qgen
    import csm_pkg::*;
(
    input  wire logic       clk,      // Core clock
    input  wire logic       reset_n,  // Asynchronous reset
    output logic [1:0]      quarter   // Current quarter phase
);
    // ************************************************************
    // Quarter counter
    // ************************************************************
    // Wraps Q4 back to Q1
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quarter <= Q1;
        end else begin
            quarter <= quarter + 2'd1;
        end
    end
endmodule

// ### csm_decode.sv
// Decode and sequencing of compare-skip, register move and bank literal load.
// Assumes instr is stable for a whole instruction cycle and data reads return in the same cycle.
// Function
// - Compare register to working register unsigned; change no status flag.
// - Skip-if-less: on register below working, discard next fetch, run no-op.
// - Skipped two-word instruction: three cycles total, both extra cycles no-op.
// - Access bit zero: address via access bank, ignore bank select.
// - Access bit one: address uses bank select register value.
// - Move: read source in Q2 of first cycle; no write in Q3, Q4.
// - Move second cycle decodes second word; no read in Q2.
// - Move writes source value into destination in Q4 of second cycle.
// - Bank literal load puts 8-bit literal into bank select; one cycle, no flags.
// - Bank literal load reads literal in Q2, writes bank select in Q4.
// - Skip-if-greater: on register above working, discard next fetch, run no-op.
`timescale 1ns/1ps
module csm_decode
    import csm_pkg::*;
(
    input  wire logic [15:0]  instr,      // Current instruction word
    input  wire logic         clk,        // Core clock
    input  wire logic         reset_n,    // Asynchronous reset
    input  wire logic [7:0]   workingReg, // Working register value
    input  wire logic [7:0]   rdData,     // Data memory read data
    output logic [11:0]       memAddr,    // Data memory address
    output logic              memRd,      // Read strobe
    output logic              memWr,      // Write strobe
    output logic [7:0]        memWrData,  // Write data
    output logic [7:0]        bankSelReg, // Bank select register
    output logic [1:0]        qPhase,     // Quarter phase, one clock behind quarter
    output logic              cycleNop,   // Current cycle is a forced no-op
    output logic              fetchDiscard // Pulse: next fetch discarded
);
    // ************************************************************
    // Quarter phases
    // ************************************************************
    logic [1:0]   quarter;
    csm_state_e   state_r;
    logic [7:0]   regVal_r;
    logic [7:0]   literal_r;
    logic         skipPend_r;

    csm_qgen u_qgen (
        .clk     (clk),
        .reset_n (reset_n),
        .quarter (quarter)
    );

    // Address of a banked operand
    function automatic logic [11:0] bankAddr(input logic a, input logic [7:0] f,
                                             input logic [7:0] bankSel);
        if (!a) begin
            bankAddr = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIBANK, f};
        end else begin
            bankAddr = {bankSel[3:0], f};
        end
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    logic isLess, isGreater, isCmp, isMove, isBsl, isTwoWord;
    always_comb begin
        isLess    = (instr[15:9] == OP_CPSLT);
        isGreater = (instr[15:9] == OP_CPSGT);
        isCmp     = isLess || isGreater;
        isMove    = (instr[15:12] == OP_MOVE1);
        isBsl     = (instr[15:8] == OP_BSLOAD);
        isTwoWord = (instr[15:12] == OP_MOVE2) || isMove;
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Skip decision uses compare of Q2 read; status flags untouched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_EXEC;
            skipPend_r <= 1'b0;
        end else if (quarter == Q4) begin
            case (state_r)
                ST_EXEC: begin
                    if (skipPend_r) begin
                        state_r <= ST_SKIP;
                    end else if (isMove) begin
                        state_r <= ST_MOVE2;
                    end
                    skipPend_r <= 1'b0;
                end
                ST_SKIP: begin
                    // Skipped first word of a two-word instruction: one more no-op
                    if (isTwoWord && instr[15:12] != OP_MOVE2) begin
                        state_r <= ST_SKIP;
                    end else begin
                        state_r <= ST_EXEC;
                    end
                end
                ST_MOVE2: state_r <= ST_EXEC;
                default:  state_r <= ST_EXEC;
            endcase
        end else if (quarter == Q3 && state_r == ST_EXEC && isCmp) begin
            skipPend_r <= isLess ? (regVal_r < workingReg)
                                 : (regVal_r > workingReg);
        end
    end

    // ************************************************************
    // Memory strobes and data
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memAddr   <= 12'h000;
            memRd     <= 1'b0;
            memWr     <= 1'b0;
            memWrData <= 8'h00;
            regVal_r  <= 8'h00;
            literal_r <= 8'h00;
        end else begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            // Strobes are set one clock ahead so they stand during the quarter
            if (quarter == Q1 && state_r == ST_EXEC) begin
                if (isCmp) begin
                    memAddr <= bankAddr(instr[8], instr[7:0], bankSelReg);
                    memRd   <= 1'b1;
                end else if (isMove) begin
                    memAddr <= instr[11:0];
                    memRd   <= 1'b1;
                end
                literal_r <= instr[7:0];
            end
            if (quarter == Q2 && state_r == ST_EXEC) begin
                regVal_r <= rdData;
            end
            // Second cycle: no read in Q2, write in Q4
            if (quarter == Q3 && state_r == ST_MOVE2) begin
                memAddr   <= instr[11:0];
                memWrData <= regVal_r;
                memWr     <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Bank select register
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bankSelReg <= BANK_SEL_RESET;
        end else if (quarter == Q4 && state_r == ST_EXEC && isBsl) begin
            bankSelReg <= literal_r;
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qPhase       <= Q1;
            cycleNop     <= 1'b0;
            fetchDiscard <= 1'b0;
        end else begin
            qPhase       <= quarter;
            // Tracks the sequencer's next state so it covers whole skipped cycles
            if (quarter == Q4) begin
                cycleNop <= (state_r == ST_EXEC && skipPend_r)
                            || (state_r == ST_SKIP && isMove);
            end
            fetchDiscard <= (quarter == Q4) && (state_r == ST_EXEC) && skipPend_r;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_bslAtQ4;
        (quarter == Q4 && state_r == ST_EXEC && isBsl) ##1 1'b1;
    endsequence
    property p_bsl_load;
        @(posedge clk) disable iff (!reset_n)
        s_bslAtQ4 |-> bankSelReg == $past(literal_r);
    endproperty
    a_bsl_load: assert property (p_bsl_load) else $error("bank load wrong");

    property p_move_no_q2_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == ST_MOVE2) |-> !memRd;
    endproperty
    a_move_no_q2_read: assert property (p_move_no_q2_read) else $error("read in move 2");

    property p_move_write;
        @(posedge clk) disable iff (!reset_n)
        memWr |-> memWrData == regVal_r && qPhase == Q3;
    endproperty
    a_move_write: assert property (p_move_write) else $error("move write timing");

    property p_no_write_first;
        @(posedge clk) disable iff (!reset_n)
        (state_r == ST_EXEC) |-> !memWr;
    endproperty
    a_no_write_first: assert property (p_no_write_first) else $error("write in cycle 1");

    property p_skip_follows;
        @(posedge clk) disable iff (!reset_n)
        fetchDiscard |-> state_r == ST_SKIP;
    endproperty
    a_skip_follows: assert property (p_skip_follows) else $error("no skip cycle");

    property p_skip_len;
        @(posedge clk) disable iff (!reset_n)
        $rose(state_r == ST_SKIP) |-> (state_r == ST_SKIP) [*4];
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip too short");

    property p_nop_state;
        @(posedge clk) disable iff (!reset_n)
        cycleNop == (state_r == ST_SKIP);
    endproperty
    a_nop_state: assert property (p_nop_state) else $error("no-op flag off");

    property p_access_bank;
        @(posedge clk) disable iff (!reset_n)
        (quarter == Q1 && state_r == ST_EXEC && isCmp && !instr[8] && instr[7])
        |=> memAddr[11:8] == ACCESS_HIBANK;
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank");

    property p_banked;
        @(posedge clk) disable iff (!reset_n)
        (quarter == Q1 && state_r == ST_EXEC && isCmp && instr[8])
        |=> memAddr[11:8] == $past(bankSelReg[3:0]);
    endproperty
    a_banked: assert property (p_banked) else $error("banked address");
endmodule

// ### tb_compare_skip_move_decode.sv
// Self-checking testbench for the compare-skip and move decode block.
// Assumes qPhase lags the quarter by one clock and strobes show in their quarter.
`timescale 1ns/1ps
module tb_compare_skip_move_decode;
    import csm_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk;
    logic        reset_n;
    logic [15:0] instr;
    logic [7:0]  workingReg;
    logic [7:0]  rdData;
    logic [11:0] memAddr;
    logic        memRd;
    logic        memWr;
    logic [7:0]  memWrData;
    logic [7:0]  bankSelReg;
    logic [1:0]  qPhase;
    logic        cycleNop;
    logic        fetchDiscard;
    logic [15:0] rdN, wrN, discN, nopN, d;
    logic [11:0] rdA, wrA;
    logic [7:0]  wrD;
    logic [7:0]  bankIn;
    logic [1:0]  qIn;
    int          n_errors;
    int          cmp_count;

    csm_decode dut (.instr(instr), .clk(clk), .reset_n(reset_n), .workingReg(workingReg),
        .rdData(rdData), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
        .memWrData(memWrData), .bankSelReg(bankSelReg), .qPhase(qPhase),
        .cycleNop(cycleNop), .fetchDiscard(fetchDiscard));

    // Clock at 50 MHz
    always #10 clk = ~clk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One instruction cycle from a Q1 edge, sampling each quarter at its falling edge
    task automatic cyc(input logic [15:0] ins);
        rdN = 16'h0000;
        wrN = 16'h0000;
        discN = 16'h0000;
        nopN = 16'h0000;
        instr <= ins;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            // Values left standing by the previous cycle's last edge
            if (i == 0) begin
                bankIn = bankSelReg;
                qIn    = qPhase;
            end
            if (memRd === 1'b1) begin
                rdN++;
                rdA = memAddr;
            end
            if (memWr === 1'b1) begin
                wrN++;
                wrA = memAddr;
                wrD = memWrData;
            end
            if (fetchDiscard === 1'b1) discN++;
            if (cycleNop === 1'b1) nopN++;
            @(posedge clk);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Compare, then one following word; checks discard and forced no-op
    task automatic tSkip(input logic [6:0] op, input logic [7:0] f, input logic [7:0] w,
                         input logic sk);
        rdData <= f;
        workingReg <= w;
        cyc({OP_BSLOAD, 8'h02});
        cyc({op, 1'b0, 8'h10});
        d = discN;
        chk(rdN, 16'h0001);
        cyc({OP_BSLOAD, 8'h05});
        chk(d + discN, {15'h0000, sk});
        chk(nopN, sk ? 16'h0004 : 16'h0000);
        cyc(16'h0000);
        chk(nopN, 16'h0000);
        chk({8'h00, bankIn}, sk ? 16'h0002 : 16'h0005);
    endtask

    // Skip over a two-word move and over a lone second word
    task automatic tSkipWords();
        rdData <= 8'h01;
        workingReg <= 8'h40;
        cyc({OP_CPSLT, 1'b0, 8'h10});
        cyc(16'hC123);
        chk(nopN, 16'h0004);
        cyc(16'hF456);
        chk(nopN, 16'h0004);
        chk(wrN, 16'h0000);
        cyc({OP_CPSLT, 1'b0, 8'h10});
        cyc(16'hF456);
        chk(nopN + wrN + rdN, 16'h0004);
        cyc({OP_BSLOAD, 8'h07});
        chk(nopN, 16'h0000);
        cyc(16'h0000);
        chk({8'h00, bankIn}, 16'h0007);
    endtask

    // Two-word move: read in cycle one, write in cycle two
    task automatic tMove();
        rdData <= 8'h33;
        cyc(16'hC0A5);
        chk(rdN, 16'h0001);
        chk({4'h0, rdA}, 16'h00A5);
        chk(wrN, 16'h0000);
        rdData <= 8'hEE;
        cyc(16'hF1B3);
        chk(rdN, 16'h0000);
        chk(wrN, 16'h0001);
        chk({4'h0, wrA}, 16'h01B3);
        chk({8'h00, wrD}, 16'h0033);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        instr = 16'h0000;
        workingReg = 8'h00;
        rdData = 8'h00;
        n_errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        chk({8'h00, bankSelReg}, 16'h0000);
        // Align to a Q1 edge
        for (int i = 0; i < 8 && qPhase !== Q3; i++) @(negedge clk);
        @(posedge clk);
        cyc({OP_BSLOAD, 8'h3C});
        chk(rdN + wrN + nopN, 16'h0000);
        cyc({OP_BSLOAD, 8'h02});
        chk({8'h00, bankIn}, 16'h003C);
        chk({14'h0000, qIn}, {14'h0000, Q4});
        rdData <= 8'h50;
        workingReg <= 8'h10;
        cyc({OP_CPSLT, 1'b0, 8'h20});
        chk({8'h00, bankIn}, 16'h0002);
        chk({4'h0, rdA}, 16'h0020);
        cyc({OP_CPSLT, 1'b0, 8'h90});
        chk({4'h0, rdA}, 16'h0F90);
        cyc({OP_CPSLT, 1'b1, 8'h20});
        chk({4'h0, rdA}, 16'h0220);
        tSkip(OP_CPSLT, 8'h10, 8'h20, 1'b1);
        tSkip(OP_CPSLT, 8'h20, 8'h20, 1'b0);
        tSkip(OP_CPSLT, 8'h80, 8'h01, 1'b0);
        tSkip(OP_CPSGT, 8'h80, 8'h01, 1'b1);
        tSkip(OP_CPSGT, 8'h20, 8'h20, 1'b0);
        tSkipWords();
        tMove();
        summarize();
    end

    initial begin
        #50000;
        n_errors++;
        summarize();
    end
endmodule
